// [ccs_pkg.sv]
// package: register address, field positions and reset values for comparator control
package ccs_pkg;
  localparam logic [7:0] CMP_CTRL_ADDR  = 8'h9b;
  localparam logic [7:0] CMP_CTRL_RESET = 8'h00;
  localparam int         EN_BIT         = 7;
  localparam int         OUT_BIT        = 6;
  localparam int         RISE_BIT       = 5;
  localparam int         FALL_BIT       = 4;
  localparam int         HYP_LSB        = 2;
  localparam int         HYN_LSB        = 0;
  localparam int         SYNC_STAGES    = 2;

  typedef enum logic [1:0] {
    HYS_OFF,
    HYS_LEVEL1,
    HYS_LEVEL2,
    HYS_LEVEL3
  } ccs_hyst_t;
endpackage

// [ccs_edge_if.sv]
// interface: level and edge events between edge detector and register logic
`timescale 1ns/10ps
interface ccs_edge_if;
  logic level;
  logic rise;
  logic fall;
  modport det (output level, output rise, output fall);
  modport reg_side (input level, input rise, input fall);
endinterface

// [ccs_edge_det.sv]
// edge detector: synchronises the analog result and reports edges
`timescale 1ns/10ps
module ccs_edge_det (
  // clock and reset
  input  wire logic  clock,
  input  wire logic  rst_n,
  input  wire logic  clk_en,
  // analog side
  input  wire logic  raw_in,
  input  wire logic  enable,
  // events
  ccs_edge_if.det    ev
);
  logic sync1_q;
  logic sync2_q;
  logic prev_q;

  // the first stage feeds only the second: the core output is asynchronous
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q  <= 1'b0;
    end else if (clk_en) begin
      sync1_q <= raw_in & enable;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  assign ev.level = sync2_q;
  assign ev.rise  = clk_en & sync2_q & ~prev_q;
  assign ev.fall  = clk_en & ~sync2_q & prev_q;

  rise_one_cycle_a : assert property (@(posedge clock) disable iff (!rst_n)
    ev.rise |=> !ev.rise) else $error("rise event lasted two cycles");
  fall_one_cycle_a : assert property (@(posedge clock) disable iff (!rst_n)
    ev.fall |=> !ev.fall) else $error("fall event lasted two cycles");
  edge_exclusive_a : assert property (@(posedge clock) disable iff (!rst_n)
    !(ev.rise && ev.fall)) else $error("rise and fall together");
endmodule // ccs_edge_det

// [ccs_top.sv]
// comparator control register: enable, output level, edge flags, hysteresis
`timescale 1ns/10ps
module ccs_top (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  // special function register port
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       sfr_rd,
  output logic      [7:0] sfr_rdata,
  // comparator core
  input  wire logic       cmp_core_out,
  output logic            cmp_enable,
  output logic            cmp_low_power,
  output logic      [1:0] cmp_pos_hysteresis,
  output logic      [1:0] cmp_neg_hysteresis
);
  logic       en_q;
  logic       rise_q;
  logic       fall_q;
  logic [1:0] hyp_q;
  logic [1:0] hyn_q;

  ccs_edge_if ev ();

  ccs_edge_det u_det (
    .clock  (clock),
    .rst_n  (rst_n),
    .clk_en (clk_en),
    .raw_in (cmp_core_out),
    .enable (en_q),
    .ev     (ev.det)
  );

  wire sel      = (sfr_addr == ccs_pkg::CMP_CTRL_ADDR);
  wire wr_hit   = sfr_wr & sel;
  wire rd_hit   = sfr_rd & sel;
  // writing 0 clears a flag unless its edge arrives in the same cycle, writing 1 sets it (software may force events)
  wire rise_d   = ev.rise | (wr_hit ? sfr_wdata[ccs_pkg::RISE_BIT] : rise_q);
  wire fall_d   = ev.fall | (wr_hit ? sfr_wdata[ccs_pkg::FALL_BIT] : fall_q);
  wire [7:0] status_word = {en_q, ev.level, rise_q, fall_q, hyp_q, hyn_q};
  wire [7:0] rdata_d     = rd_hit ? status_word : 8'h00;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      en_q   <= ccs_pkg::CMP_CTRL_RESET[ccs_pkg::EN_BIT];
      rise_q <= ccs_pkg::CMP_CTRL_RESET[ccs_pkg::RISE_BIT];
      fall_q <= ccs_pkg::CMP_CTRL_RESET[ccs_pkg::FALL_BIT];
      hyp_q  <= ccs_pkg::CMP_CTRL_RESET[3:2];
      hyn_q  <= ccs_pkg::CMP_CTRL_RESET[1:0];
    end else if (clk_en) begin
      rise_q <= rise_d;
      fall_q <= fall_d;
      if (wr_hit) begin
        en_q  <= sfr_wdata[ccs_pkg::EN_BIT];
        hyp_q <= sfr_wdata[ccs_pkg::HYP_LSB +: 2];
        hyn_q <= sfr_wdata[ccs_pkg::HYN_LSB +: 2];
      end
    end
  end

  // output flops mirror control state one cycle later
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cmp_enable         <= 1'b0;
      cmp_low_power      <= 1'b1;
      cmp_pos_hysteresis <= ccs_pkg::HYS_OFF;
      cmp_neg_hysteresis <= ccs_pkg::HYS_OFF;
      sfr_rdata          <= 8'h00;
    end else if (clk_en) begin
      cmp_enable         <= en_q;
      cmp_low_power      <= ~en_q;
      cmp_pos_hysteresis <= hyp_q;
      cmp_neg_hysteresis <= hyn_q;
      sfr_rdata          <= rdata_d;
    end
  end

  set_beats_clear_a : assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && ev.rise |=> rise_q) else $error("rise flag lost");
  fall_sticky_a : assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && ev.fall |=> fall_q) else $error("fall flag lost");
  rise_holds_a : assert property (@(posedge clock) disable iff (!rst_n)
    rise_q && !wr_hit |=> rise_q) else $error("rise flag dropped");
  low_power_a : assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && wr_hit && !sfr_wdata[7] ##1 clk_en |=> cmp_low_power)
    else $error("no low power after disable");
  enable_out_a : assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && wr_hit ##1 clk_en |=> cmp_enable == $past(sfr_wdata[7], 2))
    else $error("enable not applied");
  pos_hyst_a : assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && wr_hit ##1 clk_en
    |=> cmp_pos_hysteresis == $past(sfr_wdata[3:2], 2))
    else $error("positive hysteresis wrong");
  neg_hyst_a : assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && wr_hit ##1 clk_en
    |=> cmp_neg_hysteresis == $past(sfr_wdata[1:0], 2))
    else $error("negative hysteresis wrong");
  level_read_a : assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && rd_hit |=> sfr_rdata[6] == $past(ev.level))
    else $error("output level misread");

  // flags only move on an edge or a write hit
  fall_holds_a : assert property (@(posedge clock) disable iff (!rst_n)
    fall_q && !wr_hit |=> fall_q) else $error("fall flag dropped");
  rise_clear_a : assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && wr_hit && !sfr_wdata[5] && !ev.rise |=> !rise_q)
    else $error("rise flag not cleared");
  fall_clear_a : assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && wr_hit && !sfr_wdata[4] && !ev.fall |=> !fall_q)
    else $error("fall flag not cleared");
  fall_beats_clear_a : assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && ev.fall && wr_hit |=> fall_q)
    else $error("fall lost to clear");

  // read path
  idle_rdata_a : assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && !rd_hit |=> sfr_rdata == 8'h00)
    else $error("read data not idle");
  rise_read_a : assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && rd_hit |=> sfr_rdata[5] == $past(rise_q))
    else $error("rise flag misread");
  fall_read_a : assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && rd_hit |=> sfr_rdata[4] == $past(fall_q))
    else $error("fall flag misread");
  hyst_read_a : assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && rd_hit |=> sfr_rdata[3:0] == $past({hyp_q, hyn_q}))
    else $error("hysteresis misread");
  en_read_a : assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && rd_hit |=> sfr_rdata[7] == $past(en_q))
    else $error("enable misread");

  // control state is held between writes and while frozen
  low_power_inv_a : assert property (@(posedge clock) disable iff (!rst_n)
    cmp_low_power == !cmp_enable)
    else $error("low power not inverse of enable");
  en_hold_a : assert property (@(posedge clock) disable iff (!rst_n)
    !(clk_en && wr_hit) |=> $stable(en_q))
    else $error("enable changed without write");
  hyst_hold_a : assert property (@(posedge clock) disable iff (!rst_n)
    !(clk_en && wr_hit) |=> $stable({hyp_q, hyn_q}))
    else $error("hysteresis changed without write");
  freeze_rdata_a : assert property (@(posedge clock) disable iff (!rst_n)
    !clk_en |=> $stable(sfr_rdata))
    else $error("read data moved while frozen");
  freeze_flags_a : assert property (@(posedge clock) disable iff (!rst_n)
    !clk_en |=> $stable({rise_q, fall_q}))
    else $error("flags moved while frozen");

  cover_rise_c : cover property (@(posedge clock) disable iff (!rst_n)
    ev.rise ##[1:20] rise_q && wr_hit && !sfr_wdata[5]);
  cover_fall_c : cover property (@(posedge clock) disable iff (!rst_n)
    ev.fall && wr_hit);
  cover_dis_c : cover property (@(posedge clock) disable iff (!rst_n)
    cmp_enable ##1 cmp_low_power);
  cover_freeze_c : cover property (@(posedge clock) disable iff (!rst_n)
    !clk_en && wr_hit);
  cover_read_c : cover property (@(posedge clock) disable iff (!rst_n)
    clk_en && rd_hit && ev.level);
endmodule // ccs_top

// [ccs_core_model.sv]
// comparator core model: compares two input levels
`timescale 1ns/10ps
module ccs_core_model (
  // control
  input  wire logic       clock,
  input  wire logic       enable,
  // analog levels
  input  wire logic [7:0] pos_in,
  input  wire logic [7:0] neg_in,
  output logic            out
);
  // a powered-down core holds its output low
  always_ff @(posedge clock) begin
    out <= enable & (pos_in > neg_in);
  end
endmodule // ccs_core_model

// [test_comparator_control_status.sv]
// testbench: register access, edge flags and hysteresis
`timescale 1ns/10ps
module test_comparator_control_status;
  logic       clock, rst_n, wr, rd, co, en_o, lp_o, ce;
  logic [7:0] addr, wd, rdata, pos, neg;
  logic [1:0] hp_o, hn_o;
  int         miscompares = 0, checked = 0, cyc = 0, seed = 32'h650d9ab9;
  int         en, lv, rf, ff, hy, i, r, nl;
  ccs_top DUT (.clock(clock), .rst_n(rst_n), .clk_en(ce), .sfr_addr(addr),
    .sfr_wr(wr), .sfr_wdata(wd), .sfr_rd(rd), .sfr_rdata(rdata),
    .cmp_core_out(co), .cmp_enable(en_o), .cmp_low_power(lp_o),
    .cmp_pos_hysteresis(hp_o), .cmp_neg_hysteresis(hn_o));
  ccs_core_model core (.clock(clock), .enable(en_o), .pos_in(pos),
    .neg_in(neg), .out(co));
  task automatic chk(string nm, logic [7:0] s, logic [7:0] e);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic acc(logic w, logic [7:0] a, logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    @(posedge clock);
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
  endtask
  task automatic settle();
    repeat (8) @(posedge clock);
    nl = en && pos > neg;
    if (nl && !lv) rf = 1;
    if (!nl && lv) ff = 1;
    lv = nl;
  endtask
  task automatic rdc(logic [7:0] a);
    acc(0, a, 8'h00);
    r = en * 128 + lv * 64 + rf * 32 + ff * 16 + hy;
    chk("rdata", rdata, a == 8'h9b ? 8'(r) : 8'h00);
  endtask
  task automatic wrc(logic [7:0] d);
    en = d[7];
    rf = d[5];
    ff = d[4];
    hy = d[3:0];
    acc(1, 8'h9b, d);
    settle();
    chk("ctrl", {en_o, lp_o, 2'h0, hp_o, hn_o}, 8'(64 + en * 64 + hy));
  endtask
  task automatic results();
    if (miscompares == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    clock = 0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) if (++cyc > 5000) begin
    miscompares++;
    results();
  end
  initial begin
    {rst_n, wr, rd, addr, wd, pos, neg} = 0;
    {en, lv, rf, ff, hy} = 0;
    ce = 1'b1;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    rdc(8'h9b);
    for (i = 0; i < 4; i++) wrc(8'(8'h80 | i << 2 | (3 - i)));
    for (i = 0; i < 12; i++) begin
      r = $random(seed);
      pos <= {r[7:1], 1'b0};
      neg <= {r[15:9], 1'b1};
      settle();
      rdc(8'h9b);
      if (i % 4 == 3) wrc(8'(8'h80 | r[19:16] | r[21:20] << 4));
    end
    acc(1, 8'h9a, 8'hff);
    rdc(8'h9a);
    rdc(8'h9b);
    // a write while frozen must leave the register untouched
    ce <= 1'b0;
    acc(1, 8'h9b, 8'h0f);
    ce <= 1'b1;
    rdc(8'h9b);
    wrc(8'h00);
    rdc(8'h9b);
    results();
  end
endmodule // test_comparator_control_status
